//--- src/lpm_power_ctrl.sv
// Low-power mode control and system options register of a small microcontroller.
// Assumes stop/wait decode pulses and timer interrupts come from aclk logic;
// pins and analog detector outputs are asynchronous and are synchronised here.
`timescale 1ns/100ps
module lpm_power_ctrl
#(
  parameter bit STOP_OPT = 1'b1,
  parameter bit WATCHDOG_OPT = 1'b1,
  parameter bit LV_RESET_OPT = 1'b1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic irq_pin_n,
  input wire logic irq_ack,
  input wire logic keypad_int,
  input wire logic core_timer_int,
  input wire logic capture_timer_int,
  input wire logic lv_int_detect,
  input wire logic lv_reset_detect,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic internal_reset,
  output logic osc_enable,
  output logic cpu_halted,
  output logic timers_run,
  output logic watchdog_run,
  output logic watchdog_enable,
  output logic tone_run,
  output logic bus_clk,
  output logic timer_flags_clear,
  output logic int_mask_clear,
  output logic wake,
  output logic ext_irq_req,
  output logic lv_irq_req,
  output logic keypad_flag_clear,
  output logic portc_pullup_enable
);
  import lpm_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 3'h1;
      sync2 <= 3'h1;
    end
    else
    begin
      sync1 <= {lv_reset_detect, lv_int_detect, reset_pin_i};
      sync2 <= sync1;
    end
  end
  wire rst_pin_n = sync2[0];
  wire lv_low = sync2[1];
  wire lv_reset_low = sync2[2];
  // Internal reset leaves mode and options at their reset values
  wire next_int_reset = ~rst_pin_n | (LV_RESET_OPT & lv_reset_low);
  wire soft_rst = internal_reset;

  // ****************************************
  // Options register
  // ****************************************
  logic low_voltage_flag;
  logic low_voltage_int_enable;
  logic low_voltage_detector_on;
  logic bus_clock_slow_select;
  logic irq_level_sense;
  lpm_mode_t mode;
  logic aw_held;
  logic w_held;
  logic [5:0] aw_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  wire wr_commit = aw_held & w_held & ~s_axi_bvalid;
  wire wr_opts = wr_commit & wr_lane & (aw_idx == OPTS_IDX);
  wire wr_hit = (aw_idx == OPTS_IDX) | (aw_idx == STAT_IDX);
  // Enable accepted only while the detector is already on
  wire low_voltage_int_enable_ok = low_voltage_detector_on;
  // Flag set wins over a software clear in the same cycle
  wire lv_set = low_voltage_detector_on & lv_low;
  wire next_lvf = lv_set | (low_voltage_flag & ~(wr_opts & ~wr_byte[LVF_BIT]));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_rst)
    begin
      low_voltage_flag <= OPTS_RST[LVF_BIT];
      low_voltage_int_enable <= OPTS_RST[LV_INT_EN_BIT];
      low_voltage_detector_on <= OPTS_RST[LVON_BIT];
      bus_clock_slow_select <= OPTS_RST[SLOW_BIT];
      irq_level_sense <= OPTS_RST[SENS_BIT];
      portc_pullup_enable <= OPTS_RST[PULLUP_BIT];
      keypad_flag_clear <= 1'b0;
    end
    else
    begin
      low_voltage_flag <= next_lvf;
      keypad_flag_clear <= wr_opts & wr_byte[KCLR_BIT];
      if (wr_opts)
      begin
        low_voltage_detector_on <= wr_byte[LVON_BIT];
        low_voltage_int_enable <= wr_byte[LV_INT_EN_BIT] & low_voltage_int_enable_ok & wr_byte[LVON_BIT];
        bus_clock_slow_select <= wr_byte[SLOW_BIT];
        irq_level_sense <= wr_byte[SENS_BIT];
        portc_pullup_enable <= wr_byte[PULLUP_BIT];
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  wire [7:0] opts_read = {low_voltage_flag, low_voltage_int_enable, low_voltage_detector_on,
    bus_clock_slow_select, irq_level_sense, 1'b0, 1'b0, portc_pullup_enable};
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire rd_opts = ar_idx == OPTS_IDX;
  wire rd_stat = ar_idx == STAT_IDX;
  wire [7:0] stat_read = {4'h0, ext_irq_req, lv_irq_req, mode};
  wire [31:0] next_rdata = rd_opts ? {24'h0, opts_read} : (rd_stat ? {24'h0, stat_read} : 32'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h0;
      wr_byte <= 8'h0;
      wr_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
        s_axi_awready <= 1'b0;
      end
      else if (!aw_held && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      else if (!w_held && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
      if (wr_commit)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (rd_opts || rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ****************************************
  // Wake sources
  // ****************************************
  logic ext_pending;
  lpm_irq_sense u_irq_sense
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .irq_pin_n(irq_pin_n),
    .level_mode(irq_level_sense),
    .ack(irq_ack),
    .pending(ext_pending)
  );
  wire next_lv_irq = low_voltage_flag & low_voltage_int_enable;
  // Oscillator-off wake set is narrower than the wait set
  wire stop_wake = ext_pending | keypad_int | lv_irq_req;
  wire wait_wake = stop_wake | core_timer_int | capture_timer_int;

  // ****************************************
  // Mode sequencer
  // ****************************************
  lpm_mode_t next_mode;
  logic next_wake;
  always_comb
  begin
    next_mode = mode;
    next_wake = 1'b0;
    case (mode)
      MODE_RUN:
      begin
        if (stop_exec && STOP_OPT)
          next_mode = MODE_STOP;
        else if (wait_exec)
          next_mode = MODE_WAIT;
        // A stop opcode with the option off falls through as a no-operation.
      end
      MODE_WAIT:
      begin
        if (wait_wake)
        begin
          next_mode = MODE_RUN;
          next_wake = 1'b1;
        end
      end
      MODE_STOP:
      begin
        if (stop_wake)
        begin
          next_mode = MODE_RUN;
          next_wake = 1'b1;
        end
      end
      default:
        next_mode = MODE_RUN;
    endcase
  end
  wire enter_stop = (mode == MODE_RUN) & (next_mode == MODE_STOP);
  wire enter_wait = (mode == MODE_RUN) & (next_mode == MODE_WAIT);
  wire osc_on = next_mode != MODE_STOP;

  // Reset of any kind ends stop or wait at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_rst)
    begin
      mode <= MODE_RUN;
      wake <= 1'b0;
      timer_flags_clear <= 1'b0;
      int_mask_clear <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      wake <= next_wake;
      timer_flags_clear <= enter_stop;
      int_mask_clear <= enter_stop | enter_wait;
    end
  end

  // ****************************************
  // Clock gating and status outputs
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      internal_reset <= 1'b0;
      reset_pin_o <= 1'b0;
      reset_pin_oe <= 1'b0;
      osc_enable <= 1'b1;
      cpu_halted <= 1'b0;
      timers_run <= 1'b1;
      watchdog_run <= 1'b0;
      watchdog_enable <= 1'b0;
      tone_run <= 1'b1;
      ext_irq_req <= 1'b0;
      lv_irq_req <= 1'b0;
    end
    else
    begin
      internal_reset <= next_int_reset;
      // Only a low-voltage reset is driven out on the reset pin
      reset_pin_oe <= LV_RESET_OPT & lv_reset_low;
      osc_enable <= osc_on;
      cpu_halted <= next_mode != MODE_RUN;
      timers_run <= osc_on;
      watchdog_run <= WATCHDOG_OPT & osc_on;
      watchdog_enable <= WATCHDOG_OPT;
      tone_run <= osc_on;
      ext_irq_req <= ext_pending;
      lv_irq_req <= next_lv_irq;
    end
  end

  lpm_clk_div u_clk_div
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(osc_enable),
    .slow_sel(bus_clock_slow_select),
    .bus_clk(bus_clk)
  );
endmodule // lpm_power_ctrl

//--- src/lpm_pkg.sv
// Constants shared by the power-mode and system-options logic.
// Assumes a byte-addressed AXI4-Lite bus with one register per aligned word.
package lpm_pkg;
  // ****************************************
  // Register map (index; byte address is index times four)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [5:0] OPTS_IDX = 6'h3d;
  localparam logic [5:0] STAT_IDX = 6'h3e;
  localparam logic [7:0] OPTS_RST = 8'h00;
  // ****************************************
  // System options fields
  // ****************************************
  localparam int LVF_BIT = 7;
  localparam int LV_INT_EN_BIT = 6;
  localparam int LVON_BIT = 5;
  localparam int SLOW_BIT = 4;
  localparam int SENS_BIT = 3;
  localparam int KCLR_BIT = 1;
  localparam int PULLUP_BIT = 0;
  // ****************************************
  // Bus answers and modes
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} lpm_mode_t;
endpackage

//--- src/lpm_irq_sense.sv
// External interrupt input: synchroniser plus edge or edge-and-level detection.
// Assumes the pin is asynchronous and active low; ack comes from the CPU clock domain.
`timescale 1ns/100ps
module lpm_irq_sense
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_pin_n,
  input wire logic level_mode,
  input wire logic ack,
  output logic pending
);
  import lpm_pkg::*;
  logic sync1;
  logic sync2;
  logic prev;
  logic edge_latch;
  wire fall = prev & ~sync2;
  wire next_latch = fall | (edge_latch & ~ack);
  // Level term holds the request while the pin stays low
  wire next_pending = next_latch | (level_mode & ~sync2);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
      edge_latch <= 1'b0;
      pending <= 1'b0;
    end
    else
    begin
      sync1 <= irq_pin_n;
      sync2 <= sync1;
      prev <= sync2;
      edge_latch <= next_latch;
      pending <= next_pending;
    end
  end
endmodule // lpm_irq_sense

//--- src/lpm_clk_div.sv
// Bus clock divider: oscillator over two or four, switched only at period end.
// Assumes aclk stands for the oscillator; run low parks the clock low.
`timescale 1ns/100ps
module lpm_clk_div
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic slow_sel,
  output logic bus_clk
);
  import lpm_pkg::*;
  logic slow_q;
  logic cnt;
  wire half_done = slow_q ? cnt : 1'b1;
  // Parked only in the low phase so no short high pulse escapes
  wire hold = ~run & ~bus_clk;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_clk <= 1'b0;
      cnt <= 1'b0;
      slow_q <= 1'b0;
    end
    else if (hold)
    begin
      cnt <= 1'b0;
      slow_q <= slow_sel;
    end
    else if (half_done)
    begin
      bus_clk <= ~bus_clk;
      cnt <= 1'b0;
      if (bus_clk)
        slow_q <= slow_sel;
    end
    else
      cnt <= 1'b1;
  end
endmodule // lpm_clk_div

//--- dv/lpm_power_ctrl_assertions.sv
// Port-level assertions for the power-mode and options block.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/100ps
module lpm_power_ctrl_assertions
#(
  parameter bit STOP_OPT = 1'b1,
  parameter bit LV_RESET_OPT = 1'b1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic keypad_int,
  input wire logic core_timer_int,
  input wire logic lv_reset_detect,
  input wire logic s_axi_bvalid,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic internal_reset,
  input wire logic osc_enable,
  input wire logic cpu_halted,
  input wire logic timers_run,
  input wire logic watchdog_run,
  input wire logic tone_run,
  input wire logic bus_clk,
  input wire logic timer_flags_clear,
  input wire logic int_mask_clear,
  input wire logic wake,
  input wire logic keypad_flag_clear
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ****************
  // Mode entry and exit
  // ****************
  sequence s_stopped;
    !osc_enable && cpu_halted && !timers_run && !watchdog_run && !tone_run;
  endsequence
  sequence s_stop_pulses;
    timer_flags_clear && int_mask_clear;
  endsequence
  a_stop_entry: assert property (
    stop_exec && STOP_OPT && !cpu_halted && !internal_reset |=> s_stopped ##0 s_stop_pulses)
    else $error("stop entry outputs wrong");
  a_wait_entry: assert property (
    wait_exec && !stop_exec && !cpu_halted && !internal_reset
    |=> cpu_halted && osc_enable && timers_run && tone_run && int_mask_clear && !timer_flags_clear)
    else $error("wait entry outputs wrong");
  a_stop_wake: assert property (
    cpu_halted && !osc_enable && keypad_int && !internal_reset |=> wake && osc_enable && !cpu_halted)
    else $error("keypad did not end stop");
  a_wait_wake: assert property (
    cpu_halted && osc_enable && core_timer_int && !internal_reset |=> wake && !cpu_halted)
    else $error("timer did not end wait");
  a_mask_pulse: assert property (
    int_mask_clear |-> $rose(cpu_halted))
    else $error("mask clear outside entry");
  a_lv_reset_out: assert property (
    (lv_reset_detect && LV_RESET_OPT) [*5] |-> internal_reset && reset_pin_oe && !reset_pin_o)
    else $error("low-voltage reset missing");
  // ****************
  // Bus clock and options
  // ****************
  a_bclk_high: assert property (
    $rose(bus_clk) |=> !bus_clk or (bus_clk ##1 !bus_clk))
    else $error("bus clock high phase wrong");
  a_bclk_park: assert property (
    !osc_enable [*3] |-> !bus_clk)
    else $error("bus clock runs in stop");
  a_kclr_pulse: assert property (
    keypad_flag_clear |-> $rose(s_axi_bvalid))
    else $error("keypad clear not tied to write");
endmodule // lpm_power_ctrl_assertions

bind lpm_power_ctrl lpm_power_ctrl_assertions #(.STOP_OPT(STOP_OPT), .LV_RESET_OPT(LV_RESET_OPT)) i_chk (.*);

//--- dv/test_lpm_power_ctrl.sv
// Self-checking bench of the power-mode and options block.
// Assumes a 50 MHz aclk; the bench is both bus master and CPU side.
`timescale 1ns/100ps
module test_lpm_power_ctrl;
  import lpm_pkg::*;
  localparam logic [7:0] OPT_A = {OPTS_IDX, 2'b00};
  localparam logic [7:0] STAT_A = {STAT_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, stop_exec, wait_exec, irq_pin_n, irq_ack;
  logic keypad_int, core_timer_int, capture_timer_int, lv_int_detect, lv_reset_detect, reset_pin_i;
  logic reset_pin_o, reset_pin_oe, internal_reset, osc_enable, cpu_halted, timers_run, watchdog_run;
  logic watchdog_enable, tone_run, bus_clk, timer_flags_clear, int_mask_clear, wake, ext_irq_req;
  logic lv_irq_req, keypad_flag_clear, portc_pullup_enable;
  logic kclr_seen = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] opt = 8'h00;
  logic [7:0] corner [6] = '{8'h60, 8'h60, 8'h02, 8'hff, 8'h21, 8'h00};
  int mismatches = 0;
  int total_checks = 0;
  lpm_power_ctrl i_dut (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk)
    if (keypad_flag_clear)
      kclr_seen <= 1'b1;
  // ****************
  // Models and checks
  // ****************
  function automatic logic [7:0] opt_next(input logic [7:0] o, input logic [7:0] w);
    logic [7:0] n;
    n = w & 8'h39;
    n[6] = w[6] & w[5] & o[5];
    n[7] = o[7] & w[7];
    return n;
  endfunction
  function automatic logic [31:0] bclk_period(input logic slow);
    return slow ? 32'h4 : 32'h2;
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************
  // Bus and CPU drivers
  // ****************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid)
      @(posedge aclk);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic opt_set(input logic [7:0] d, input logic [3:0] s);
    kclr_seen = 1'b0;
    wr(OPT_A, d, s, r);
    chk_val({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
    if (s[0])
      opt = opt_next(opt, d);
    rd(OPT_A, q, r);
    chk_bit(kclr_seen, s[0] & d[1], "keypad clear");
    chk_bit(portc_pullup_enable, opt[0], "pull-up");
    chk_val(q, {24'h0, opt}, "options");
  endtask
  task automatic exec(input logic st);
    @(posedge aclk);
    stop_exec <= st;
    wait_exec <= !st;
    @(posedge aclk);
    stop_exec <= 1'b0;
    wait_exec <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic ack_irq;
    @(posedge aclk);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic meas(input logic slow);
    time t0;
    @(posedge bus_clk);
    t0 = $time;
    @(posedge bus_clk);
    chk_val(32'(($time - t0) / 20), bclk_period(slow), "bus clock");
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {stop_exec, wait_exec, irq_ack, keypad_int, core_timer_int, capture_timer_int} = '0;
    {lv_int_detect, lv_reset_detect, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    irq_pin_n = 1'b1;
    reset_pin_i = 1'b1;
    void'($urandom(9));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    while (internal_reset !== 1'b0)
      @(posedge aclk);
    rd(OPT_A, q, r);
    chk_val(q, 32'h0, "reset value");
    chk_bit(watchdog_enable, 1'b1, "watchdog option");
    rd(8'h00, q, r);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
    $display("test reset done");
    foreach (corner[i])
      opt_set(corner[i], 4'hf);
    opt_set(8'h3b, 4'he);
    for (int i = 0; i < 12; i++)
      opt_set(8'($urandom), 4'hf);
    $display("test options done");
    opt_set(8'h20, 4'hf);
    lv_int_detect <= 1'b1;
    repeat (5) @(posedge aclk);
    opt[7] = 1'b1;
    opt_set(8'he0, 4'hf);
    chk_bit(lv_irq_req, 1'b1, "lv request");
    lv_int_detect <= 1'b0;
    repeat (5) @(posedge aclk);
    opt_set(8'h21, 4'hf);
    chk_bit(lv_irq_req, 1'b0, "lv request off");
    $display("test low voltage done");
    exec(1'b1);
    chk_val({osc_enable, cpu_halted, timers_run, tone_run, watchdog_run}, 32'h8, "stop state");
    rd(STAT_A, q, r);
    chk_val(q, 32'h2, "mode status");
    capture_timer_int <= 1'b1;
    repeat (5) @(posedge aclk);
    chk_bit(cpu_halted, 1'b1, "timer ignored in stop");
    capture_timer_int <= 1'b0;
    keypad_int <= 1'b1;
    while (cpu_halted)
      @(posedge aclk);
    keypad_int <= 1'b0;
    opt_set(opt, 4'h0);
    $display("test stop done");
    exec(1'b0);
    chk_val({osc_enable, cpu_halted, timers_run, tone_run, watchdog_run}, 32'h1f, "wait state");
    core_timer_int <= 1'b1;
    while (cpu_halted)
      @(posedge aclk);
    core_timer_int <= 1'b0;
    $display("test wait done");
    opt_set(8'h00, 4'hf);
    meas(1'b0);
    opt_set(8'h10, 4'hf);
    meas(1'b1);
    $display("test bus clock done");
    opt_set(8'h00, 4'hf);
    irq_pin_n <= 1'b0;
    repeat (5) @(posedge aclk);
    chk_bit(ext_irq_req, 1'b1, "edge request");
    ack_irq;
    chk_bit(ext_irq_req, 1'b0, "edge acked");
    opt_set(8'h08, 4'hf);
    ack_irq;
    chk_bit(ext_irq_req, 1'b1, "level held");
    irq_pin_n <= 1'b1;
    repeat (5) @(posedge aclk);
    ack_irq;
    chk_bit(ext_irq_req, 1'b0, "level released");
    $display("test external interrupt done");
    // Supply drop only while stopped
    exec(1'b1);
    lv_reset_detect <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_bit(internal_reset & reset_pin_oe & ~reset_pin_o, 1'b1, "lv reset");
    lv_reset_detect <= 1'b0;
    while (internal_reset)
      @(posedge aclk);
    rd(OPT_A, q, r);
    chk_val(q, 32'h0, "cleared by reset");
    chk_bit(cpu_halted, 1'b0, "reset ends stop");
    $display("test low voltage reset done");
    close_out;
  end
endmodule // test_lpm_power_ctrl
